//--- hw/dsc_defines.vh
// Constants for the serial command and register logic of the converter
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define DSC_CLK_HZ          20000000
`define DSC_TIMEOUT_MS      100
// Stall limit: 100 ms of the 20 MHz clock, sized to the watchdog counter
`define DSC_TIMEOUT_CYC     22'h1E_8480

// ****************************************
// Instruction byte fields
// ****************************************
`define DSC_INS_RW          7
`define DSC_INS_LEN_HI      6
`define DSC_INS_LEN_LO      5
`define DSC_LEN_1           2'b00
`define DSC_LEN_2           2'b01
`define DSC_LEN_3           2'b10

// ****************************************
// Byte locations
// ****************************************
`define DSC_LOC_CODE_HI     4'h0
`define DSC_LOC_CODE_LO     4'h1
`define DSC_LOC_CMD_HI      4'h4
`define DSC_LOC_CMD_LO      4'h5
`define DSC_LOC_OFF_B2      4'h8
`define DSC_LOC_OFF_B1      4'h9
`define DSC_LOC_OFF_B0      4'hA
`define DSC_LOC_GAIN_B2     4'hC
`define DSC_LOC_GAIN_B1     4'hD
`define DSC_LOC_GAIN_B0     4'hE

// ****************************************
// Command register fields
// ****************************************
`define DSC_CMD_ADAPT_OFF   15
`define DSC_CMD_CAL_CONN    14
`define DSC_CMD_TRIM_CLR    9
`define DSC_CMD_CODE_CLR    6
`define DSC_CMD_FORMAT      5
`define DSC_CMD_FS_OFF      4
`define DSC_CMD_BYTE_DOWN   3
`define DSC_CMD_BIT_LSBF    2
`define DSC_CMD_MODE_HI     1
`define DSC_CMD_MODE_LO     0
`define DSC_CMD_KEEP_MASK   16'hC27F
`define DSC_CMD_FIXED_VAL   16'h2800
`define DSC_CMD_RESET       16'h2802
`define DSC_MODE_NORMAL     2'b00
`define DSC_MODE_CAL        2'b01
`define DSC_MODE_SLEEP      2'b10

// ****************************************
// Reset values
// ****************************************
`define DSC_CODE_RESET      16'h0000
`define DSC_TRIM_RESET      24'h00_0000

`endif

//--- hw/dsc_sync.v
// Three-stage input synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module dsc_sync #(
  parameter       WIDTH   = 3,
  parameter [2:0] RST_VAL = 3'b000
) (
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             ce,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge clk_sys) begin
        if (srst) begin
          s1_r  <= RST_VAL[i];
          s2_r  <= RST_VAL[i];
          s3_r  <= RST_VAL[i];
          lvl_r <= RST_VAL[i];
        end else if (ce) begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Change accepted only once the last two stages agree
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level_out[i] = lvl_r;
    end
  endgenerate

endmodule

//--- hw/dsc_serial_regs.v
// Serial instruction interpreter and register bank of the converter
`timescale 1ns/1ps
`include "dsc_defines.vh"
module dsc_serial_regs #(
  parameter [21:0] TIMEOUT_CYC = `DSC_TIMEOUT_CYC
) (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        ce,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        sdio_in,
  output reg         sdio_out,
  output reg         sdio_oe,
  input  wire        cal_done,
  input  wire [23:0] cal_offset,
  input  wire [23:0] cal_gain,
  output reg         cal_start,
  output reg         cal_busy,
  output reg  [15:0] code_out,
  output reg  [23:0] offset_trim_out,
  output reg  [23:0] gain_trim_out,
  output reg         code_format,
  output reg         cal_output_connect,
  output reg         settle_always,
  output reg         settle_adaptive,
  output reg  [1:0]  op_mode,
  output reg         sleep
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [2:0] pin_lvl;
  dsc_sync #(
    .WIDTH   (3),
    .RST_VAL (3'b110)
  ) u_sync (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .ce        (ce),
    .pin_in    ({cs_n, sdio_in, sclk}),
    .level_out (pin_lvl)
  );

  wire sclk_s  = pin_lvl[0];
  wire sdio_s  = pin_lvl[1];
  wire cs_n_s  = pin_lvl[2];

  reg  sclk_prev_r;
  wire sel     = ~cs_n_s;
  wire sclk_rise = sel & sclk_s & ~sclk_prev_r;
  wire sclk_fall = sel & ~sclk_s & sclk_prev_r;

  // ****************************************
  // State
  // ****************************************
  localparam [0:0] ST_INSTR = 1'b0;
  localparam [0:0] ST_DATA  = 1'b1;

  reg        state_r;
  reg [2:0]  bit_cnt_r;
  reg [1:0]  bytes_left_r;
  reg        read_r;
  reg [3:0]  loc_r;
  reg [7:0]  rx_r;
  reg [7:0]  tx_r;
  reg [21:0] idle_cnt_r;

  reg [15:0] code_r;
  reg [15:0] cmd_r;
  reg [23:0] off_r;
  reg [23:0] gain_r;

  reg [15:0] code_sh_r;
  reg [15:0] cmd_sh_r;
  reg [23:0] off_sh_r;
  reg [23:0] gain_sh_r;
  reg        code_tch_r;
  reg        cmd_tch_r;
  reg        off_tch_r;
  reg        gain_tch_r;
  reg        commit_r;

  wire bit_lsbf  = (state_r == ST_DATA) & cmd_r[`DSC_CMD_BIT_LSBF];
  wire byte_down = cmd_r[`DSC_CMD_BYTE_DOWN];
  wire [7:0] rx_nxt = bit_lsbf ? {sdio_s, rx_r[7:1]} : {rx_r[6:0], sdio_s};
  wire busy_tx   = (state_r == ST_DATA) | (bit_cnt_r != 3'd0);

  // Instruction byte has no location, so it is never returned
  function [7:0] rd_byte;
    input [3:0] loc;
    begin
      case (loc)
        `DSC_LOC_CODE_HI: rd_byte = code_r[15:8];
        `DSC_LOC_CODE_LO: rd_byte = code_r[7:0];
        `DSC_LOC_CMD_HI:  rd_byte = cmd_r[15:8];
        `DSC_LOC_CMD_LO:  rd_byte = cmd_r[7:0];
        `DSC_LOC_OFF_B2:  rd_byte = off_r[23:16];
        `DSC_LOC_OFF_B1:  rd_byte = off_r[15:8];
        `DSC_LOC_OFF_B0:  rd_byte = off_r[7:0];
        `DSC_LOC_GAIN_B2: rd_byte = gain_r[23:16];
        `DSC_LOC_GAIN_B1: rd_byte = gain_r[15:8];
        `DSC_LOC_GAIN_B0: rd_byte = gain_r[7:0];
        // Reserved locations read as zero
        default:          rd_byte = 8'h00;
      endcase
    end
  endfunction

  // Command writes always step upward
  wire       cmd_loc  = (loc_r == `DSC_LOC_CMD_HI) | (loc_r == `DSC_LOC_CMD_LO);
  wire       step_dn  = byte_down & ~(~read_r & cmd_loc);
  wire [3:0] loc_step = step_dn ? loc_r - 4'd1 : loc_r + 4'd1;
  wire [3:0] ins_loc  = rx_nxt[3:0];

  // ****************************************
  // Serial engine
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      sclk_prev_r  <= 1'b0;
      state_r      <= ST_INSTR;
      bit_cnt_r    <= 3'd0;
      bytes_left_r <= 2'd0;
      read_r       <= 1'b0;
      loc_r        <= 4'h0;
      rx_r         <= 8'h00;
      tx_r         <= 8'h00;
      idle_cnt_r   <= 22'd0;
      sdio_out     <= 1'b0;
      sdio_oe      <= 1'b0;
      code_sh_r    <= `DSC_CODE_RESET;
      cmd_sh_r     <= `DSC_CMD_RESET;
      off_sh_r     <= `DSC_TRIM_RESET;
      gain_sh_r    <= `DSC_TRIM_RESET;
      code_tch_r   <= 1'b0;
      cmd_tch_r    <= 1'b0;
      off_tch_r    <= 1'b0;
      gain_tch_r   <= 1'b0;
      commit_r     <= 1'b0;
    end else if (ce) begin
      sclk_prev_r <= sclk_s;
      commit_r    <= 1'b0;
      // Stall watchdog, registers left untouched
      if (sclk_rise | sclk_fall | ~busy_tx) begin
        idle_cnt_r <= 22'd0;
      end else if (idle_cnt_r == TIMEOUT_CYC - 22'd1) begin
        idle_cnt_r <= 22'd0;
        state_r    <= ST_INSTR;
        bit_cnt_r  <= 3'd0;
        sdio_oe    <= 1'b0;
      end else begin
        idle_cnt_r <= idle_cnt_r + 22'd1;
      end
      // Device changes its bit on the rising edge, host samples on falling
      if (sclk_rise && state_r == ST_DATA && read_r) begin
        sdio_out <= bit_lsbf ? tx_r[bit_cnt_r] : tx_r[3'd7 - bit_cnt_r];
      end
      if (sclk_fall) begin
        rx_r      <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 3'd1;
        if (bit_cnt_r == 3'd7) begin
          if (state_r == ST_INSTR) begin
            // Decode direction, length, start
            state_r      <= ST_DATA;
            read_r       <= rx_nxt[`DSC_INS_RW];
            bytes_left_r <= rx_nxt[`DSC_INS_LEN_HI:`DSC_INS_LEN_LO];
            loc_r        <= ins_loc;
            tx_r         <= rd_byte(ins_loc);
            sdio_oe      <= rx_nxt[`DSC_INS_RW];
            code_sh_r    <= code_r;
            cmd_sh_r     <= cmd_r;
            off_sh_r     <= off_r;
            gain_sh_r    <= gain_r;
            code_tch_r   <= 1'b0;
            cmd_tch_r    <= 1'b0;
            off_tch_r    <= 1'b0;
            gain_tch_r   <= 1'b0;
          end else begin
            if (!read_r) begin
              case (loc_r)
                `DSC_LOC_CODE_HI: begin code_sh_r[15:8] <= rx_nxt; code_tch_r <= 1'b1; end
                `DSC_LOC_CODE_LO: begin code_sh_r[7:0]  <= rx_nxt; code_tch_r <= 1'b1; end
                `DSC_LOC_CMD_HI:  begin cmd_sh_r[15:8]  <= rx_nxt; cmd_tch_r  <= 1'b1; end
                `DSC_LOC_CMD_LO:  begin cmd_sh_r[7:0]   <= rx_nxt; cmd_tch_r  <= 1'b1; end
                `DSC_LOC_OFF_B2:  begin off_sh_r[23:16] <= rx_nxt; off_tch_r  <= 1'b1; end
                `DSC_LOC_OFF_B1:  begin off_sh_r[15:8]  <= rx_nxt; off_tch_r  <= 1'b1; end
                `DSC_LOC_OFF_B0:  begin off_sh_r[7:0]   <= rx_nxt; off_tch_r  <= 1'b1; end
                `DSC_LOC_GAIN_B2: begin gain_sh_r[23:16] <= rx_nxt; gain_tch_r <= 1'b1; end
                `DSC_LOC_GAIN_B1: begin gain_sh_r[15:8] <= rx_nxt; gain_tch_r <= 1'b1; end
                `DSC_LOC_GAIN_B0: begin gain_sh_r[7:0]  <= rx_nxt; gain_tch_r <= 1'b1; end
                // Reserved: data dropped
                default: ;
              endcase
            end
            loc_r <= loc_step;
            tx_r  <= rd_byte(loc_step);
            if (bytes_left_r == 2'd0) begin
              // Count reached, wait for a fresh instruction
              state_r  <= ST_INSTR;
              sdio_oe  <= 1'b0;
              commit_r <= ~read_r;
            end else begin
              bytes_left_r <= bytes_left_r - 2'd1;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Register bank and controller
  // ****************************************
  // Commit one cycle after the final falling edge, all bytes at once
  wire [15:0] cmd_new = (cmd_sh_r & `DSC_CMD_KEEP_MASK) | `DSC_CMD_FIXED_VAL;

  always @(posedge clk_sys) begin
    if (srst) begin
      // Power-on state loads defaults, sleep mode
      code_r    <= `DSC_CODE_RESET;
      cmd_r     <= `DSC_CMD_RESET;
      off_r     <= `DSC_TRIM_RESET;
      gain_r    <= `DSC_TRIM_RESET;
      cal_busy  <= 1'b0;
      cal_start <= 1'b0;
    end else if (ce) begin
      cal_start <= 1'b0;
      if (cal_busy) begin
        // Calibration state: writes dropped until done
        if (cal_done) begin
          cal_busy <= 1'b0;
          off_r    <= cal_offset;
          gain_r   <= cal_gain;
          cmd_r[`DSC_CMD_MODE_HI:`DSC_CMD_MODE_LO] <= `DSC_MODE_NORMAL;
        end
      end else if (commit_r) begin
        if (code_tch_r) begin
          code_r <= code_sh_r;
        end
        if (off_tch_r) begin
          off_r <= off_sh_r;
        end
        if (gain_tch_r) begin
          gain_r <= gain_sh_r;
        end
        if (cmd_tch_r) begin
          cmd_r <= cmd_new;
          if (cmd_new[`DSC_CMD_CODE_CLR]) begin
            code_r <= `DSC_CODE_RESET;
          end
          if (cmd_new[`DSC_CMD_TRIM_CLR]) begin
            off_r  <= `DSC_TRIM_RESET;
            gain_r <= `DSC_TRIM_RESET;
          end
          // Reserved mode 11 is stored but starts nothing
          if (cmd_new[`DSC_CMD_MODE_HI:`DSC_CMD_MODE_LO] == `DSC_MODE_CAL) begin
            cal_busy  <= 1'b1;
            cal_start <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      code_out           <= `DSC_CODE_RESET;
      offset_trim_out    <= `DSC_TRIM_RESET;
      gain_trim_out      <= `DSC_TRIM_RESET;
      code_format        <= 1'b0;
      cal_output_connect <= 1'b0;
      settle_always      <= 1'b0;
      settle_adaptive    <= 1'b1;
      op_mode            <= `DSC_MODE_SLEEP;
      sleep              <= 1'b1;
    end else if (ce) begin
      code_out           <= code_r;
      offset_trim_out    <= off_r;
      gain_trim_out      <= gain_r;
      code_format        <= cmd_r[`DSC_CMD_FORMAT];
      cal_output_connect <= cmd_r[`DSC_CMD_CAL_CONN];
      // Off bit overrides the adaptive choice
      settle_always   <= cmd_r[`DSC_CMD_ADAPT_OFF] & ~cmd_r[`DSC_CMD_FS_OFF];
      settle_adaptive <= ~cmd_r[`DSC_CMD_ADAPT_OFF] & ~cmd_r[`DSC_CMD_FS_OFF];
      op_mode <= cmd_r[`DSC_CMD_MODE_HI:`DSC_CMD_MODE_LO];
      sleep   <= cmd_r[`DSC_CMD_MODE_HI:`DSC_CMD_MODE_LO] == `DSC_MODE_SLEEP;
    end
  end

endmodule

//--- sim/dsc_host.sv
// Behavioural host that clocks the serial link
`timescale 1ns/1ps
module dsc_host (
  output logic sclk,
  output logic cs_n,
  output wire  sdio_in,
  input  wire  sdio_out,
  input  wire  sdio_oe
);
  logic drv = 1'b1;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end

  // Released line toggles per bit so stale data never passes
  assign sdio_in = sdio_oe ? sdio_out : drv;

  task automatic xfer(input logic [7:0] ins, input logic [23:0] wd, input int n,
                      input bit lsbf, output logic [23:0] rd);
    logic [31:0] s;
    logic [31:0] rs;
    int          i;
    int          x;
    s = {ins, wd};
    rs = 32'h0000_0000;
    cs_n = 1'b0;
    #150;
    for (i = 0; i < n; i++) begin
      x = (i < 8 || !lsbf) ? 31 - i : 24 - 8 * (i / 8) + i % 8;
      drv = (ins[7] && i >= 8) ? ~drv : s[x];
      #50 sclk = 1'b1;
      #200 sclk = 1'b0;
      #100 if (ins[7] && i >= 8) rs[x] = sdio_in;
      #50;
    end
    // Cut-short frames stay selected so the stall is seen
    cs_n = (n % 8 == 0);
    rd = rs[23:0];
  endtask
endmodule

//--- sim/dsc_serial_regs_chk.sv
// Port-level assertions for the serial command block
`timescale 1ns/1ps
module dsc_chk (
  input wire        clk_sys,
  input wire        srst,
  input wire        sclk,
  input wire        sdio_out,
  input wire        sdio_oe,
  input wire        cal_done,
  input wire [23:0] cal_offset,
  input wire [23:0] cal_gain,
  input wire        cal_start,
  input wire        cal_busy,
  input wire [15:0] code_out,
  input wire [23:0] offset_trim_out,
  input wire [23:0] gain_trim_out,
  input wire        settle_always,
  input wire        settle_adaptive,
  input wire [1:0]  op_mode,
  input wire        sleep
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_reset_vals: assert property (
    $fell(srst) |-> op_mode == 2'b10 && sleep && settle_adaptive && !settle_always
      && !cal_busy && !sdio_oe && code_out == 16'h0000)
    else $error("Outputs not at defaults after reset");
  a_sleep_decode: assert property (sleep == (op_mode == 2'b10))
    else $error("Sleep flag disagrees with mode");
  a_settle_excl: assert property (!(settle_always && settle_adaptive))
    else $error("Both settling controls active");
  a_start_pulse: assert property (cal_start |=> !cal_start && cal_busy)
    else $error("Calibration start not a pulse into busy");
  a_busy_hold: assert property (cal_busy && !cal_done |=> cal_busy)
    else $error("Calibration ended without done");
  a_busy_mode: assert property (cal_busy && $past(cal_busy) |-> op_mode == 2'b01)
    else $error("Mode not self-cal while busy");
  a_done_mode: assert property ($fell(cal_busy) |-> ##[0:1] op_mode == 2'b00)
    else $error("Mode not normal after calibration");
  a_done_trims: assert property (
    cal_busy && cal_done |-> ##[1:2] offset_trim_out == cal_offset && gain_trim_out == cal_gain)
    else $error("Calibration results not loaded");
  a_out_after_rise: assert property (
    $changed(sdio_out) && sdio_oe && $past(sdio_oe) |-> $past(sclk, 3))
    else $error("Read data moved without a clock rise");

  c_cal: cover property (cal_start);
  c_read: cover property ($fell(sdio_oe));
  c_mode3: cover property (op_mode == 2'b11);
  c_settle: cover property (settle_always);
endmodule

bind dsc_serial_regs dsc_chk u_chk (
  .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .cal_done(cal_done), .cal_offset(cal_offset), .cal_gain(cal_gain), .cal_start(cal_start),
  .cal_busy(cal_busy), .code_out(code_out), .offset_trim_out(offset_trim_out),
  .gain_trim_out(gain_trim_out), .settle_always(settle_always),
  .settle_adaptive(settle_adaptive), .op_mode(op_mode), .sleep(sleep)
);

//--- sim/dac_serial_command_regs_bench.sv
// Self-checking bench for the serial command and register block
`timescale 1ns/1ps
module dac_serial_command_regs_bench;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        cal_done = 1'b0;
  logic [23:0] cal_offset = 24'h00_0000;
  logic [23:0] cal_gain = 24'h00_0000;
  wire         sclk, cs_n, sdio_in, sdio_out, sdio_oe, cal_start, cal_busy, sleep;
  wire         code_format, cal_output_connect, settle_always, settle_adaptive;
  wire  [15:0] code_out;
  wire  [23:0] offset_trim_out, gain_trim_out;
  wire  [1:0]  op_mode;
  logic [7:0]  mem [16];
  logic [31:0] hand [10] = '{32'h2012_3400, 32'hA000_0000, 32'hA400_0000, 32'h48AA_BBCC,
    32'h4C11_2233, 32'h2428_0300, 32'h24C2_7C00, 32'hA400_0000, 32'h4A55_6677, 32'h2400_0000};
  int          n_fail = 0;
  int          n_compared = 0;
  int          n_start = 0;
  bit          busy = 1'b0;

  dsc_serial_regs #(.TIMEOUT_CYC(22'h00_07D0)) DUT (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cal_done(cal_done), .cal_offset(cal_offset),
    .cal_gain(cal_gain), .cal_start(cal_start), .cal_busy(cal_busy), .code_out(code_out),
    .offset_trim_out(offset_trim_out), .gain_trim_out(gain_trim_out),
    .code_format(code_format), .cal_output_connect(cal_output_connect),
    .settle_always(settle_always), .settle_adaptive(settle_adaptive), .op_mode(op_mode),
    .sleep(sleep));
  dsc_host host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe));

  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cal_start) n_start++;

  // ****************************************
  // Expectation helpers
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic bit vld(logic [3:0] l);
    return l inside {0, 1, 4, 5, 8, 9, 10, 12, 13, 14};
  endfunction

  task outs();
    chk(code_out, {mem[0], mem[1]});
    chk({offset_trim_out, gain_trim_out}, {mem[8], mem[9], mem[10], mem[12], mem[13], mem[14]});
    chk({code_format, cal_output_connect, op_mode, sleep}, {mem[5][5], mem[4][6], mem[5][1:0], mem[5][1:0] == 2'b10});
    chk({settle_always, settle_adaptive}, {mem[4][7] & ~mem[5][4], ~mem[4][7] & ~mem[5][4]});
  endtask

  task run(input logic [7:0] ins, input logic [23:0] wd);
    logic [23:0] rd;
    logic [23:0] ex;
    logic [3:0]  l;
    bit          cw;
    bit          bd;
    int          nb;
    int          k;
    nb = ins[6:5] + 1;
    l = ins[3:0];
    ex = 24'h00_0000;
    cw = 1'b0;
    bd = mem[5][3];
    host.xfer(ins, wd, 8 + 8 * nb, mem[5][2], rd);
    for (k = 0; k < nb; k++) begin
      if (ins[7]) ex[23 - 8 * k -: 8] = vld(l) ? mem[l] : 8'h00;
      else if (vld(l) && !busy) begin
        mem[l] = wd[23 - 8 * k -: 8];
        cw |= l inside {4, 5};
      end
      l = (bd && !(!ins[7] && l inside {4, 5})) ? l - 4'h1 : l + 4'h1;
    end
    if (cw) begin
      mem[4] = mem[4] & 8'hC2 | 8'h28;
      mem[5] &= 8'h7F;
      if (mem[5][6]) {mem[0], mem[1]} = 16'h0000;
      if (mem[4][1]) {mem[8], mem[9], mem[10], mem[12], mem[13], mem[14]} = 48'h0;
      busy = mem[5][1:0] == 2'b01;
    end
    repeat (8) @(negedge clk_sys);
    if (ins[7]) chk(rd, ex);
    else outs();
  endtask

  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [23:0] rd;
    logic [7:0]  ins;
    void'($urandom(32'h0000_7808));
    foreach (mem[i]) mem[i] = 8'h00;
    mem[4] = 8'h28;
    mem[5] = 8'h02;
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    repeat (2) @(negedge clk_sys);
    outs();
    chk(sdio_oe, 1'b0);
    foreach (hand[i]) run(hand[i][31:24], hand[i][23:0]);
    repeat (40) begin
      ins = 8'($urandom);
      ins[4] = 1'b0;
      if (ins[6:5] == 2'b11) ins[6:5] = 2'b10;
      // Low mode bit kept clear so random traffic never starts calibration
      run(ins, 24'($urandom) & 24'hFE_FEFE);
    end
    host.xfer(8'h21, 24'h00_0000, 12, 1'b0, rd);
    repeat (2100) @(negedge clk_sys);
    run(8'h21, 24'h5A_0000);
    run(8'h24, 24'h28_0100);
    chk(cal_busy, 1'b1);
    run(8'h20, 24'h99_9900);
    cal_offset = 24'($urandom);
    cal_gain = 24'($urandom);
    cal_done = 1'b1;
    @(negedge clk_sys);
    cal_done = 1'b0;
    busy = 1'b0;
    mem[5][1:0] = 2'b00;
    {mem[8], mem[9], mem[10], mem[12], mem[13], mem[14]} = {cal_offset, cal_gain};
    repeat (4) @(negedge clk_sys);
    outs();
    chk(n_start, 1);
    // Frozen block must ignore a whole frame while the enable is low
    ce = 1'b0;
    host.xfer(8'h20, 24'h77_7700, 24, 1'b0, rd);
    repeat (8) @(negedge clk_sys);
    outs();
    ce = 1'b1;
    // Second reset in mid-run brings every register back to defaults
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[4] = 8'h28;
    mem[5] = 8'h02;
    repeat (2) @(negedge clk_sys);
    outs();
    run(8'hA4, 24'h00_0000);
    finish_test();
  end

  initial begin
    #3ms;
    n_fail++;
    finish_test();
  end
endmodule
